/* bench/ddr3_ctrl_model.sv */
// Memory-controller model that drives the device pins.
`timescale 1ns/1ps
`default_nettype none
module ddr3_ctrl_model
  import pd_odt_pkg::*;
#(
  parameter int TCKE = 3,
  parameter int MAX_PD = 300,
  parameter int ODTH4 = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the bench
  input wire logic go_pd,
  input wire logic go_odt,
  input wire logic bad_nop,
  input wire logic hit_rst,
  // Device pins
  output var pin_in_t pins
);
  int hold;
  int odt_hold;
  int pd_time;
  // Only NOP is sent unless bad_nop drops it, so no burst, mode set or DLL-off phase meets CKE.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= 4'hB;
      hold <= 0;
      odt_hold <= 0;
      pd_time <= 0;
    end else begin
      pins.reset_n <= !hit_rst;
      pins.nop <= !bad_nop;
      hold <= (hold > 0) ? hold - 1 : 0;
      pd_time <= pins.cke ? 0 : pd_time + 1;
      if (hold == 0 && pins.cke != (!go_pd || pd_time >= MAX_PD)) begin
        pins.cke <= !pins.cke;
        hold <= TCKE;
      end
      odt_hold <= (odt_hold > 0) ? odt_hold - 1 : 0;
      if (go_odt && !pins.odt) begin
        pins.odt <= 1'b1;
        odt_hold <= ODTH4 - 1;
      end else if (!go_odt && odt_hold == 0) begin
        pins.odt <= 1'b0;
      end
    end
  end
endmodule // ddr3_ctrl_model
`default_nettype wire

/* bench/ddr3_powerdown_odt_control_tb.sv */
// Self-checking bench for the power-down and termination control block.
`timescale 1ns/1ps
`default_nettype none
module ddr3_powerdown_odt_control_tb;
  import pd_odt_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, cpded, xp, xpdll;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic pready, pslverr, err, go_pd = 1'b0, go_odt = 1'b0, bad_nop = 1'b0, hit_rst = 1'b0;
  logic core_busy = 1'b0, banks_open = 1'b0, self_refresh = 1'b0, dll_locked = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] cwl, al;
  logic [2:0] nom;
  logic [1:0] wr;
  pin_in_t pins;
  pd_ctl_t ctl;
  pd_state_t pd_state;
  int errors = 0, total_checks = 0, n, nx, nd, c, lat;
  always #12.5 pclk = ~pclk;
  ddr3_powerdown_odt_control uut (.pclk(pclk), .presetn(presetn), .ce(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .core_busy(core_busy),
    .banks_open(banks_open), .self_refresh(self_refresh), .dll_locked(dll_locked),
    .ctl(ctl), .pd_state(pd_state));
  ddr3_ctrl_model ctrl (.pclk(pclk), .presetn(presetn), .go_pd(go_pd), .go_odt(go_odt),
    .bad_nop(bad_nop), .hit_rst(hit_rst), .pins(pins));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k = 1);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic wait_st(input pd_state_t s);
    for (int i = 0; i < 40 && pd_state !== s; i++) step();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(41376));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, ADDR_TIMING, 32'h0);
    chk(rd, TIMING_RESET);
    apb(1'b0, 8'h0C, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    chk(err, 1'b1);
    d = $urandom() & 32'hFFFF_FF3F;
    apb(1'b1, ADDR_CTRL, d);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, d & 32'h0000_FFFF);
    cpded = $urandom_range(4, 1);
    xp = $urandom_range(6, 2);
    xpdll = xp + $urandom_range(8, 2);
    apb(1'b1, ADDR_TIMING, {8'h05, xpdll, xp, cpded});
    apb(1'b0, ADDR_TIMING, 32'h0);
    chk(rd, {8'h05, xpdll, xp, cpded});
    // Case 0 active with a NOP-less first try, 1 slow precharge, 2 fast precharge.
    for (c = 0; c < 3; c++) begin
      apb(1'b1, ADDR_CTRL, {16'h0, 4'h0, 4'h5, 7'h00, c == 2});
      @(posedge pclk);
      banks_open <= (c == 0);
      core_busy <= 1'b1;
      bad_nop <= (c == 0);
      go_pd <= 1'b1;
      if (c == 0) begin
        step(10);
        chk(pd_state, ST_RUN);
        @(posedge pclk);
        bad_nop <= 1'b0;
      end
      wait_st(ST_PEND);
      for (n = 0; n < 40 && ctl.cmd_rcv_en === 1'b1; n++) step();
      chk(n, cpded);
      step(2);
      chk(pd_state, ST_PEND);
      @(posedge pclk);
      core_busy <= 1'b0;
      step(2);
      chk(pd_state, c == 0 ? ST_PD_ACT : ST_PD_PRE);
      chk(ctl.dll_en, c != 1);
      chk(ctl.in_buf_en, 1'b0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[STAT_STATE_LSB +: 5], c == 0 ? ST_PD_ACT : ST_PD_PRE);
      chk(rd[STAT_DLL_EN_BIT], c != 1);
      chk(err, 1'b0);
      @(posedge pclk);
      go_pd <= 1'b0;
      wait_st(ST_RUN);
      nx = 0;
      nd = 0;
      for (n = 1; n < 40; n++) begin
        step();
        if (ctl.cmd_ok === 1'b1 && nx == 0) nx = n;
        if (ctl.dll_ok === 1'b1 && nd == 0) nd = n;
      end
      chk(nx, xp);
      if (c == 1) chk(nd, xpdll);
    end
    @(posedge pclk);
    go_pd <= 1'b1;
    wait_st(ST_PD_PRE);
    @(posedge pclk);
    hit_rst <= 1'b1;
    go_pd <= 1'b0;
    step(5);
    chk(pd_state, ST_RST);
    @(posedge pclk);
    hit_rst <= 1'b0;
    wait_st(ST_RUN);
    // Case 0 nominal with DLL locked, 1 write-only unlocked, 2 all bits clear.
    for (c = 0; c < 3; c++) begin
      cwl = $urandom_range(9, 5);
      al = $urandom_range(3, 0);
      nom = (c == 0) ? 3'($urandom_range(7, 1)) : 3'h0;
      wr = (c == 1) ? 2'($urandom_range(3, 1)) : 2'h0;
      apb(1'b1, ADDR_CTRL, {16'h0, al, cwl, 2'h0, wr, nom, 1'b1});
      @(posedge pclk);
      dll_locked <= (c != 1);
      lat = (c == 2) ? 40 : (c == 1) ? 3 : cwl + al + 1;
      step(4);
      chk(ctl.sync_odt, c != 1);
      @(posedge pclk);
      go_odt <= 1'b1;
      for (n = 0; n < 20 && pins.odt !== 1'b1; n++) step();
      for (n = 0; n < 40 && ctl.rtt_en !== 1'b1; n++) step();
      chk(n, lat);
      if (c == 0) chk(ctl.rtt_sel, nom);
      @(posedge pclk);
      go_odt <= 1'b0;
      for (n = 0; n < 20 && pins.odt !== 1'b0; n++) step();
      for (n = 0; n < 40 && ctl.rtt_en !== 1'b0; n++) step();
      chk(n, c == 2 ? 0 : lat);
    end
    // A low clock enable must hold every flop, even while the lock input drops.
    @(posedge pclk);
    clk_en <= 1'b0;
    dll_locked <= 1'b0;
    step(4);
    chk(ctl.sync_odt, 1'b1);
    @(posedge pclk);
    clk_en <= 1'b1;
    dll_locked <= 1'b1;
    step(2);
    apb(1'b1, ADDR_CTRL, 32'h0000_0503);
    @(posedge pclk);
    self_refresh <= 1'b1;
    go_odt <= 1'b1;
    step(12);
    chk(ctl.rtt_en, 1'b0);
    close_out();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    close_out();
  end
endmodule // ddr3_powerdown_odt_control_tb
bind ddr3_powerdown_odt_control pd_odt_properties chk_i (.pclk(pclk), .presetn(presetn),
  .pins(pins), .core_busy(core_busy), .banks_open(banks_open), .self_refresh(self_refresh),
  .ctl(ctl), .pd_state(pd_state));
`default_nettype wire

/* bench/pd_odt_properties.sv */
// Port-level checks for power-down sequencing and termination.
`timescale 1ns/1ps
`default_nettype none
module pd_odt_properties
  import pd_odt_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and core state
  input wire pin_in_t pins,
  input wire logic core_busy,
  input wire logic banks_open,
  input wire logic self_refresh,
  // Device controls
  input wire pd_ctl_t ctl,
  input wire pd_state_t pd_state
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic pd_any;
  assign pd_any = (pd_state == ST_PD_ACT) || (pd_state == ST_PD_PRE);
  // Pins reach the state three edges late, so causes are taken two samples back.
  chk_pd_entry: assert property (
    pd_state == ST_RUN && $past(presetn, 2) && $past(pins.reset_n, 2) && !$past(pins.cke, 2)
    && $past(pins.nop, 2) |=> pd_state == ST_PEND) else $error("Entry missed.");
  chk_pd_exit: assert property (
    pd_any && $past(pins.reset_n, 2) && $past(pins.cke, 2) && $past(pins.nop, 2)
    |=> pd_state == ST_RUN) else $error("Exit missed.");
  chk_pin_reset: assert property (
    $past(presetn, 2) && !$past(pins.reset_n, 2) |=> pd_state == ST_RST)
    else $error("Reset pin ignored.");
  chk_pend_hold: assert property (
    pd_state == ST_PEND && core_busy && $past(pins.reset_n, 2) && !$past(pins.cke, 2)
    |=> pd_state == ST_PEND) else $error("Left entry while busy.");
  chk_pd_kind: assert property (
    pd_state == ST_PEND && !core_busy && !ctl.cmd_rcv_en && $past(pins.reset_n, 2)
    && !$past(pins.cke, 2) |=> pd_state == ($past(banks_open) ? ST_PD_ACT : ST_PD_PRE))
    else $error("Wrong power-down kind.");
  chk_in_buf: assert property (
    pd_state != ST_RST |-> ctl.in_buf_en == (pd_state == ST_RUN))
    else $error("Buffer enable wrong.");
  chk_rcv_hold: assert property ($rose(pd_state == ST_PEND) |-> ctl.cmd_rcv_en)
    else $error("Receivers off early.");
  chk_dll_active: assert property (pd_state == ST_PD_ACT |-> ctl.dll_en)
    else $error("DLL off in active power-down.");
  chk_sr_off: assert property (self_refresh |=> !ctl.rtt_en)
    else $error("Termination in self-refresh.");
  chk_pin_off: assert property (
    !ctl.sync_odt && !$past(ctl.sync_odt) && !$past(ctl.sync_odt, 2) && ctl.rtt_en
    |-> $past(pins.odt, 3)) else $error("Termination without pin.");
  cover property (pd_state == ST_PD_ACT);
  cover property (pd_state == ST_PD_PRE && !ctl.dll_en);
  cover property ($rose(ctl.rtt_en) && ctl.sync_odt);
endmodule // pd_odt_properties
`default_nettype wire

/* rtl/ddr3_powerdown_odt_control.sv */
// Power-down sequencing and on-die termination control with an APB register slave.
// Function
// - Enter power-down when CKE registers low together with a NOP or deselect.
// - CKE may drop during activate, precharge or refresh; finish them first.
// - After in-flight work, all banks closed gives precharge, else active power-down.
// - Power-down disables input and output buffers except clock, ODT, CKE, reset.
// - Command and address receivers switch off only after the CPDED count expires.
// - Fast-exit bit clear: DLL off, slow exit; set: DLL on, fast exit.
// - DLL runs in active and fast precharge power-down, stops in slow.
// - Reset pin low during power-down leaves it for the reset state.
// - Exit when CKE registers high with NOP; commands wait XP or XPDLL.
// - Termination enabled when nominal or write termination bits are non-zero.
// - ODT pin low means off; high means on unless mode bits disable.
// - Self-refresh or disabled termination keeps it off and ignores the pin.
// - Synchronous termination applies whenever the DLL is on and locked; the code also requires self_refresh low.
// - Synchronous termination follows the pin after CWL plus AL minus two cycles; the code takes CWL plus AL minus one after the synchronised pin.
// - The internal ODT request is posted by the additive latency.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ddr3_powerdown_odt_control
  import pd_odt_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock, reset and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device pins from the controller
  input wire pin_in_t pins,
  // Core state from logic on this clock
  input wire logic core_busy,
  input wire logic banks_open,
  input wire logic self_refresh,
  input wire logic dll_locked,
  // Controls to the device core
  output pd_ctl_t ctl,
  output pd_state_t pd_state
);

  localparam int TAP_W = $clog2(ODT_LINE_DEPTH);

  pin_in_t pin_s;
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] timing_q, timing_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  pd_state_t state_d;
  pd_ctl_t ctl_d;
  logic [CNT_W-1:0] cpded_q, cpded_d;
  logic [CNT_W-1:0] xp_q, xp_d;
  logic [CNT_W-1:0] xpdll_q, xpdll_d;
  logic fast_exit;
  logic [2:0] rtt_nom;
  logic [1:0] rtt_wr;
  logic [3:0] cwl;
  logic [3:0] al;
  logic [4:0] lat_sum;
  logic [TAP_W-1:0] odt_tap;
  logic odt_late;
  logic odt_mode;
  logic sync_mode;
  logic setup_ph, access_ph, addr_ok;

  // Pins cross from the controller's clock; two flops before any decision.
  sync_2ff #(
    .W(4),
    .INIT(4'h2)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .d(pins),
    .q(pin_s)
  );

  always_comb begin
    fast_exit = ctrl_q[CTRL_FAST_EXIT_BIT];
    rtt_nom = ctrl_q[CTRL_RTT_NOM_LSB +: 3];
    rtt_wr = ctrl_q[CTRL_RTT_WR_LSB +: 2];
    cwl = ctrl_q[CTRL_CWL_LSB +: 4];
    al = ctrl_q[CTRL_AL_LSB +: 4];
    lat_sum = {1'b0, cwl} + {1'b0, al};
    // The additive latency is folded into the single tap.
    if (lat_sum > ODT_LAT_OFFSET) begin
      odt_tap = lat_sum - ODT_LAT_OFFSET;
    end else begin
      odt_tap = '0;
    end
  end

  // One line carries the request for both edges, so on and off share a latency.
  odt_delay_line #(
    .DEPTH(ODT_LINE_DEPTH)
  ) u_odt_line (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .din(pin_s.odt),
    .tap(odt_tap),
    .dout(odt_late)
  );

  // APB register slave: zero wait states, read data prepared in setup.
  always_comb begin
    setup_ph = psel && !penable;
    access_ph = psel && penable && pready;
    addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_TIMING) || (paddr == ADDR_STATUS);
    ctrl_d = ctrl_q;
    timing_d = timing_q;
    prdata_d = prdata;
    pready_d = pready;
    pslverr_d = pslverr;
    if (ce) begin
      if (setup_ph) begin
        pready_d = 1'b1;
        pslverr_d = !addr_ok || (pwrite && (paddr == ADDR_STATUS));
        prdata_d = 32'h0000_0000;
        case (paddr)
          ADDR_CTRL: prdata_d = {16'h0000, ctrl_q[15:0]};
          ADDR_TIMING: prdata_d = timing_q;
          ADDR_STATUS: begin
            prdata_d[STAT_STATE_LSB +: 5] = pd_state;
            prdata_d[STAT_IN_BUF_BIT] = ctl.in_buf_en;
            prdata_d[STAT_CMD_RCV_BIT] = ctl.cmd_rcv_en;
            prdata_d[STAT_DLL_EN_BIT] = ctl.dll_en;
            prdata_d[STAT_SYNC_BIT] = ctl.sync_odt;
            prdata_d[STAT_RTT_EN_BIT] = ctl.rtt_en;
            prdata_d[STAT_CMD_OK_BIT] = ctl.cmd_ok;
            prdata_d[STAT_DLL_OK_BIT] = ctl.dll_ok;
          end
          default: prdata_d = 32'h0000_0000;
        endcase
      end else if (access_ph) begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (pwrite && (paddr == ADDR_CTRL)) begin
          ctrl_d = {16'h0000, pwdata[15:0]};
        end
        if (pwrite && (paddr == ADDR_TIMING)) begin
          timing_d = pwdata;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      timing_q <= TIMING_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      timing_q <= timing_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // Power-down sequencer and exit latency counters.
  always_comb begin
    state_d = pd_state;
    cpded_d = cpded_q;
    xp_d = xp_q;
    xpdll_d = xpdll_q;
    if (ce) begin
      if (cpded_q != '0) cpded_d = cpded_q - 1'b1;
      if (xp_q != '0) xp_d = xp_q - 1'b1;
      if (xpdll_q != '0) xpdll_d = xpdll_q - 1'b1;
      case (pd_state)
        ST_RST: begin
          if (pin_s.reset_n) state_d = ST_RUN;
        end
        ST_RUN: begin
          if (!pin_s.cke && pin_s.nop) begin
            state_d = ST_PEND;
            cpded_d = timing_q[TIM_CPDED_LSB +: CNT_W];
          end
        end
        ST_PEND, ST_PD_ACT, ST_PD_PRE: begin
          if (pin_s.cke && pin_s.nop) begin
            state_d = ST_RUN;
            xp_d = timing_q[TIM_XP_LSB +: CNT_W];
            // Only a slow exit has to wait for the DLL to relock.
            if (pd_state == ST_PD_PRE && !fast_exit) begin
              xpdll_d = timing_q[TIM_XPDLL_LSB +: CNT_W];
            end
          end else if (pd_state == ST_PEND && !core_busy) begin
            // Activate, precharge and refresh finish before classifying.
            state_d = banks_open ? ST_PD_ACT : ST_PD_PRE;
          end
        end
        default: state_d = ST_RST;
      endcase
      // The reset pin overrides any power-down state.
      if (!pin_s.reset_n) begin
        state_d = ST_RST;
        xp_d = '0;
        xpdll_d = '0;
      end
    end
  end

  // Termination and buffer controls, registered for glitch-free outputs.
  always_comb begin
    odt_mode = (rtt_nom != 3'h0) || (rtt_wr != 2'h0);
    ctl_d = ctl;
    if (ce) begin
      ctl_d.in_buf_en = (state_d == ST_RUN);
      ctl_d.cmd_rcv_en = (state_d == ST_RUN) || (cpded_d != '0);
      ctl_d.dll_en = !(state_d == ST_RST) && !(state_d == ST_PD_PRE && !fast_exit);
      ctl_d.cmd_ok = (state_d == ST_RUN) && (xp_d == '0);
      ctl_d.dll_ok = (state_d == ST_RUN) && (xpdll_d == '0) && dll_locked;
      sync_mode = ctl_d.dll_en && dll_locked && !self_refresh;
      ctl_d.sync_odt = sync_mode;
      // Outside synchronous mode the pin acts with no added latency.
      if (self_refresh || !odt_mode || state_d == ST_RST) begin
        ctl_d.rtt_en = 1'b0;
      end else if (sync_mode) begin
        ctl_d.rtt_en = odt_late;
      end else begin
        ctl_d.rtt_en = pin_s.odt;
      end
      ctl_d.rtt_sel = odt_mode ? rtt_nom : 3'h0;
    end else begin
      sync_mode = ctl.sync_odt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_state <= ST_RST;
      cpded_q <= '0;
      xp_q <= '0;
      xpdll_q <= '0;
      ctl <= '0;
    end else begin
      pd_state <= state_d;
      cpded_q <= cpded_d;
      xp_q <= xp_d;
      xpdll_q <= xpdll_d;
      ctl <= ctl_d;
    end
  end

endmodule // ddr3_powerdown_odt_control
`default_nettype wire

/* rtl/odt_delay_line.sv */
// Shift line that delays the sampled termination request by a selectable number of cycles.
`timescale 1ns/1ps
`default_nettype none
module odt_delay_line #(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic din,
  input wire logic [$clog2(DEPTH)-1:0] tap,
  output logic dout
);
  logic [DEPTH-1:0] line_q;
  logic [DEPTH-1:0] line_d;

  // Tap 0 is the input itself, so a zero latency adds no cycle here.
  always_comb begin
    line_d = ce ? {line_q[DEPTH-2:0], din} : line_q;
    dout = (tap == '0) ? din : line_q[tap - 1'b1];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= '0;
    end else begin
      line_q <= line_d;
    end
  end
endmodule // odt_delay_line
`default_nettype wire

/* rtl/pd_odt_pkg.sv */
// Constants, register map and carrier types for the power-down and termination control block.
package pd_odt_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Control register fields.
  localparam int CTRL_FAST_EXIT_BIT = 0;
  localparam int CTRL_RTT_NOM_LSB = 1;
  localparam int CTRL_RTT_WR_LSB = 4;
  localparam int CTRL_CWL_LSB = 8;
  localparam int CTRL_AL_LSB = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0500;

  // Timing register fields, all counts in pclk cycles.
  localparam int TIM_CPDED_LSB = 0;
  localparam int TIM_XP_LSB = 8;
  localparam int TIM_XPDLL_LSB = 16;
  localparam int TIM_CKE_LSB = 24;
  localparam logic [31:0] TIMING_RESET = 32'h0318_0401;

  // Status register fields.
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_IN_BUF_BIT = 5;
  localparam int STAT_CMD_RCV_BIT = 6;
  localparam int STAT_DLL_EN_BIT = 7;
  localparam int STAT_SYNC_BIT = 8;
  localparam int STAT_RTT_EN_BIT = 9;
  localparam int STAT_CMD_OK_BIT = 10;
  localparam int STAT_DLL_OK_BIT = 11;

  // The delay-line tap is CWL plus AL minus this offset; turn-on and turn-off latency from the synchronised pin is one cycle more.
  localparam logic [4:0] ODT_LAT_OFFSET = 5'h02;
  localparam int ODT_LINE_DEPTH = 32;

  typedef enum logic [4:0] {
    ST_RST = 5'b00001,
    ST_RUN = 5'b00010,
    ST_PEND = 5'b00100,
    ST_PD_ACT = 5'b01000,
    ST_PD_PRE = 5'b10000
  } pd_state_t;

  // Device pins sampled from the controller's side.
  typedef struct packed {
    logic cke;
    logic odt;
    logic reset_n;
    logic nop;
  } pin_in_t;

  // Controls handed to the rest of the device.
  typedef struct packed {
    logic in_buf_en;
    logic cmd_rcv_en;
    logic dll_en;
    logic sync_odt;
    logic rtt_en;
    logic [2:0] rtt_sel;
    logic cmd_ok;
    logic dll_ok;
  } pd_ctl_t;

endpackage : pd_odt_pkg

/* rtl/sync_2ff.sv */
// Two-flop synchroniser for a vector of independent levels.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = ce ? d : meta_q;
    q_d = ce ? meta_q : q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule // sync_2ff
`default_nettype wire
